/* File: common/lvf_defines.svh */
// Purpose: offsets, field positions, reset values and codes of the
//          legacy vector fault check block.
// Assumes: included by bare name from the design and the testbench.
// Notes:   all numbers of the block live here once.
//
// How it works
// - Category order: prior traps, interrupts, fetch, decode, then execution faults.
// - Inside the execution category our own fixed order is used.
// - Unmasked vector float fault with vector-fault support clear gives invalid opcode.
// - Unmasked vector float fault with vector-fault support set gives vector float fault.
// - Emulation flag set gives invalid opcode in every mode.
// - Extended-save support clear gives invalid opcode in every mode.
// - Bus-lock prefix on the instruction gives invalid opcode.
// - Any zero feature-enumeration flag for the instruction gives invalid opcode.
// - Pending legacy float unit fault gives the pending float fault.
// - Protected mode illegal stack-segment address gives stack fault, code zero.
// - 64-bit mode non-canonical stack address gives stack fault, code zero.
// - Double-to-int group operand not 16-byte aligned gives protection fault.
// - Protected mode illegal code or data segment address gives protection fault.
// - 64-bit mode non-canonical non-stack address gives protection fault.
// - Real or virtual-8086 operand past FFFFH gives protection fault.
// - Single group unaligned at level 3 with checking on, outside real mode, gives alignment fault.
// - 16-byte rule for double group, alignment-check rule for single group.

`ifndef LVF_DEFINES_SVH
`define LVF_DEFINES_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define LVF_OFS_MCTRL     8'h00
`define LVF_OFS_FCTRL     8'h04
`define LVF_OFS_STATUS    8'h08
`define LVF_OFS_IRQ_EN    8'h0C
`define LVF_OFS_IRQ_CLR   8'h10
`define LVF_OFS_LAST      8'h14
`define LVF_OFS_LAST_CODE 8'h18

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define LVF_BIT_EMUL      2
`define LVF_BIT_TSW       3
`define LVF_BIT_XSAVE     9
`define LVF_BIT_VFAULT    10
`define LVF_MCTRL_RST     32'h0000_0000
`define LVF_FCTRL_RST     32'h0000_0000
`define LVF_IRQ_EN_RST    8'h00

// ***************************************************************
// Fault vectors, sizes and limits
// ***************************************************************
`define LVF_VEC_UD        8'h06
`define LVF_VEC_NM        8'h07
`define LVF_VEC_SS        8'h0C
`define LVF_VEC_GP        8'h0D
`define LVF_VEC_PF        8'h0E
`define LVF_VEC_MF        8'h10
`define LVF_VEC_AC        8'h11
`define LVF_VEC_XM        8'h13
`define LVF_SIZE_DBL      17'h0_0010
`define LVF_SIZE_SGL      17'h0_0008
`define LVF_REAL_LIMIT    17'h0_FFFF
`define LVF_CPL_USER      2'h3
`define LVF_NFAULT        8

`endif

/* File: common/lvf_pkg.sv */
// Purpose: types shared by the legacy vector fault check block.
// Assumes: lvf_defines.svh on the include path.
// Notes:   request and response travel as packed structs.

package lvf_pkg;

	// ***************************************************************
	// Enumerations
	// ***************************************************************
	typedef enum logic [1:0] {MODE_REAL, MODE_V86, MODE_PROT, MODE_LONG} lvf_mode_t;
	typedef enum logic {GRP_DBL, GRP_SGL} lvf_grp_t;
	typedef enum logic [2:0] {
		CAT_NONE, CAT_TRAP, CAT_INTR, CAT_FETCH, CAT_DECODE, CAT_EXEC
	} lvf_cat_t;
	typedef enum logic [3:0] {
		FLT_NONE, FLT_UD, FLT_NM, FLT_MF, FLT_SS, FLT_GP, FLT_PF, FLT_AC, FLT_XM
	} lvf_fault_t;

	// ***************************************************************
	// Request from the pipeline, answer back to it
	// ***************************************************************
	typedef struct packed {
		logic        valid;
		logic        prev_trap;
		logic        ext_intr;
		logic        fetch_flt;
		logic        decode_flt;
		lvf_mode_t   mode;
		lvf_grp_t    grp;
		logic        lock_pfx;
		logic        feat_ok;
		logic        x87_pend;
		logic        simd_unm;
		logic        mem_op;
		logic        ss_seg;
		logic        seg_bad;
		logic [63:0] addr;
		logic [1:0]  cpl;
		logic        ac_en;
		logic        page_flt;
		logic [31:0] pf_code;
	} lvf_req_t;

	typedef struct packed {
		logic        valid;
		lvf_cat_t    cat;
		lvf_fault_t  fault;
		logic [7:0]  vector;
		logic        code_valid;
		logic [31:0] code;
	} lvf_rsp_t;

endpackage : lvf_pkg

/* File: hw/lvf_prio.sv */
// Purpose: picks the winning exception category and execution fault.
// Assumes: exec_flt_i bit k stands for fault FLT_NONE+1+k.
// Notes:   purely combinational.

`timescale 1ns/1ps

module lvf_prio (
	input  wire logic                 prev_trap_i,
	input  wire logic                 ext_intr_i,
	input  wire logic                 fetch_flt_i,
	input  wire logic                 decode_flt_i,
	input  wire logic [7:0]           exec_flt_i,
	output lvf_pkg::lvf_cat_t         cat_o,
	output lvf_pkg::lvf_fault_t       fault_o
);
	import lvf_pkg::*;

	// ***************************************************************
	// Lowest set execution bit wins
	// ***************************************************************
	function automatic lvf_fault_t first_fault(input logic [7:0] v);
		lvf_fault_t f;
		f = FLT_NONE;
		for (int k = 7; k >= 0; k--) begin
			if (v[k]) begin
				f = lvf_fault_t'(4'(k + 1));
			end
		end
		return f;
	endfunction : first_fault

	wire lvf_fault_t exec_win = first_fault(exec_flt_i);

	// Categories in fixed order, execution last
	assign cat_o = prev_trap_i  ? CAT_TRAP   :
	               ext_intr_i   ? CAT_INTR   :
	               fetch_flt_i  ? CAT_FETCH  :
	               decode_flt_i ? CAT_DECODE :
	               (|exec_flt_i) ? CAT_EXEC : CAT_NONE;

	// Only execution faults are named here
	assign fault_o = (cat_o == CAT_EXEC) ? exec_win : FLT_NONE;

endmodule : lvf_prio

/* File: hw/lvf_top.sv */
// Purpose: fault check for legacy packed conversion instructions.
// Assumes: one request per cycle from the pipeline, AHB-Lite registers.
// Notes:   answer is registered, one cycle after the request.

`timescale 1ns/1ps
`include "lvf_defines.svh"

module lvf_top (
	input  wire logic              clk_sys_i,
	input  wire logic              sys_rst_i,
	// Check request and answer
	input  lvf_pkg::lvf_req_t      req_i,
	output lvf_pkg::lvf_rsp_t      rsp_o,
	// AHB-Lite slave
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	output logic [31:0]            hrdata_o,
	// Interrupt
	output logic                   irq_o
);
	import lvf_pkg::*;

	// ***************************************************************
	// Helper functions
	// ***************************************************************

	// Upper address bits all equal the sign bit
	function automatic logic is_canon(input logic [63:0] a);
		return (&a[63:47]) | ~(|a[63:47]);
	endfunction : is_canon

	// Operand end beyond the 64 KiB real-mode window
	function automatic logic past_limit(input logic [63:0] a, input lvf_grp_t g);
		logic [16:0] last;
		last = {1'b0, a[15:0]} + ((g == GRP_DBL) ? `LVF_SIZE_DBL : `LVF_SIZE_SGL)
		       - 17'h0_0001;
		return (last > `LVF_REAL_LIMIT) | (|a[63:16]);
	endfunction : past_limit

	// Vector number of an execution fault
	function automatic logic [7:0] fault_vec(input lvf_fault_t f);
		logic [7:0] v;
		case (f)
			FLT_UD:  v = `LVF_VEC_UD;
			FLT_NM:  v = `LVF_VEC_NM;
			FLT_MF:  v = `LVF_VEC_MF;
			FLT_SS:  v = `LVF_VEC_SS;
			FLT_GP:  v = `LVF_VEC_GP;
			FLT_PF:  v = `LVF_VEC_PF;
			FLT_AC:  v = `LVF_VEC_AC;
			FLT_XM:  v = `LVF_VEC_XM;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : fault_vec

	// Faults that push an error code
	function automatic logic has_code(input lvf_fault_t f);
		return (f == FLT_SS) | (f == FLT_GP) | (f == FLT_PF) | (f == FLT_AC);
	endfunction : has_code

	// ***************************************************************
	// Registers
	// ***************************************************************
	logic [31:0] mctrl_ff;
	logic [31:0] fctrl_ff;
	logic [7:0]  status_ff;
	logic [7:0]  irq_en_ff;
	logic [31:0] last_ff;
	logic [31:0] last_code_ff;
	logic [31:0] nxt_mctrl;
	logic [31:0] nxt_fctrl;
	logic [7:0]  nxt_status;
	logic [7:0]  nxt_irq_en;
	logic [31:0] nxt_last;
	logic [31:0] nxt_last_code;

	lvf_rsp_t    rsp_ff;
	lvf_rsp_t    nxt_rsp;

	// AHB data-phase state
	logic        wr_pend_ff;
	logic [7:0]  wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata;

	// ***************************************************************
	// Mode and control decode
	// ***************************************************************
	wire logic is_real = (req_i.mode == MODE_REAL);
	wire logic is_v86  = (req_i.mode == MODE_V86);
	wire logic is_prot = (req_i.mode == MODE_PROT);
	wire logic is_long = (req_i.mode == MODE_LONG);

	wire logic emul_on  = mctrl_ff[`LVF_BIT_EMUL];
	wire logic tsw_on   = mctrl_ff[`LVF_BIT_TSW];
	wire logic xsave_on = fctrl_ff[`LVF_BIT_XSAVE];
	wire logic vflt_on  = fctrl_ff[`LVF_BIT_VFAULT];

	// Address checks used by several faults
	wire logic canon    = is_canon(req_i.addr);
	wire logic over_64k = past_limit(req_i.addr, req_i.grp);
	wire logic mis16    = |req_i.addr[3:0];
	wire logic mis8     = |req_i.addr[2:0];
	wire logic grp_dbl  = (req_i.grp == GRP_DBL);
	wire logic grp_sgl  = (req_i.grp == GRP_SGL);
	wire logic mem      = req_i.mem_op;

	// ***************************************************************
	// Execution fault conditions
	// ***************************************************************

	// Invalid opcode causes, any mode
	wire logic ud_vflt  = req_i.simd_unm & ~vflt_on;
	wire logic ud_emul  = emul_on;
	wire logic ud_xsave = ~xsave_on;
	wire logic ud_lock  = req_i.lock_pfx;
	wire logic ud_feat  = ~req_i.feat_ok;
	wire logic flt_ud   = ud_vflt | ud_emul | ud_xsave | ud_lock | ud_feat;

	// Pending legacy float and task switch
	wire logic flt_mf = req_i.x87_pend;
	wire logic flt_nm = tsw_on;

	// Stack segment faults
	wire logic ss_prot = mem & req_i.ss_seg & is_prot & req_i.seg_bad;
	wire logic ss_long = mem & req_i.ss_seg & is_long & ~canon;
	wire logic flt_ss  = ss_prot | ss_long;

	// Protection faults
	wire logic gp_align = mem & grp_dbl & mis16;
	wire logic gp_prot  = mem & ~req_i.ss_seg & is_prot & req_i.seg_bad;
	wire logic gp_long  = mem & ~req_i.ss_seg & is_long & ~canon;
	wire logic gp_real  = mem & (is_real | is_v86) & over_64k;
	wire logic flt_gp   = gp_align | gp_prot | gp_long | gp_real;

	// Translation fault, never in real mode
	wire logic flt_pf = mem & req_i.page_flt & ~is_real;

	// Alignment check for the single group only
	wire logic ac_user = (req_i.cpl == `LVF_CPL_USER) & req_i.ac_en;
	wire logic flt_ac  = mem & grp_sgl & ~is_real & ac_user & mis8;

	// Vector float fault with support enabled
	wire logic flt_xm = req_i.simd_unm & vflt_on;

	// Order within execution: UD, NM, MF, SS, GP, PF, AC, XM
	wire logic [7:0] exec_flt = req_i.valid ?
		{flt_xm, flt_ac, flt_pf, flt_gp, flt_ss, flt_mf, flt_nm, flt_ud} : 8'h00;

	// ***************************************************************
	// Category and fault selection
	// ***************************************************************
	lvf_cat_t   win_cat;
	lvf_fault_t win_flt;

	lvf_prio u_prio (
		.prev_trap_i  (req_i.valid & req_i.prev_trap),
		.ext_intr_i   (req_i.valid & req_i.ext_intr),
		.fetch_flt_i  (req_i.valid & req_i.fetch_flt),
		.decode_flt_i (req_i.valid & req_i.decode_flt),
		.exec_flt_i   (exec_flt),
		.cat_o        (win_cat),
		.fault_o      (win_flt)
	);

	// Error code: zero except translation fault
	wire logic [31:0] win_code = (win_flt == FLT_PF) ? req_i.pf_code : 32'h0000_0000;
	wire logic        win_evt  = req_i.valid & (win_flt != FLT_NONE);

	// Answer built from the winner
	always_comb begin
		nxt_rsp            = '0;
		nxt_rsp.valid      = req_i.valid;
		nxt_rsp.cat        = win_cat;
		nxt_rsp.fault      = win_flt;
		nxt_rsp.vector     = fault_vec(win_flt);
		nxt_rsp.code_valid = has_code(win_flt);
		nxt_rsp.code       = win_code;
	end

	// ***************************************************************
	// AHB-Lite decode
	// ***************************************************************
	wire logic       ahb_go  = hsel_i & htrans_i[1] & hready_i;
	wire logic       ahb_wr  = ahb_go & hwrite_i;
	wire logic       ahb_rd  = ahb_go & ~hwrite_i;
	wire logic [7:0] ahb_ofs = haddr_i[7:0];
	wire logic       wr_word = wr_pend_ff; // Upper address bits are aliased away

	// Data-phase write strobes per register
	wire logic we_mctrl  = wr_word & (wr_addr_ff == `LVF_OFS_MCTRL);
	wire logic we_fctrl  = wr_word & (wr_addr_ff == `LVF_OFS_FCTRL);
	wire logic we_irq_en = wr_word & (wr_addr_ff == `LVF_OFS_IRQ_EN);
	wire logic we_clr    = wr_word & (wr_addr_ff == `LVF_OFS_IRQ_CLR);

	// Status bit raised by this cycle's fault
	wire logic [7:0] set_bits = win_evt ?
		(8'h01 << (4'(win_flt) - 4'h1)) : 8'h00;

	// ***************************************************************
	// Next-state logic of the registers
	// ***************************************************************
	assign nxt_mctrl  = we_mctrl  ? hwdata_i : mctrl_ff;
	assign nxt_fctrl  = we_fctrl  ? hwdata_i : fctrl_ff;
	assign nxt_irq_en = we_irq_en ? hwdata_i[7:0] : irq_en_ff;

	// Set wins over a clear in the same cycle
	assign nxt_status = (status_ff & ~(we_clr ? hwdata_i[7:0] : 8'h00)) | set_bits;

	// Last fault seen: category, fault and vector
	assign nxt_last = win_evt ?
		{13'h0000, 3'(win_cat), 4'h0, 4'(win_flt), fault_vec(win_flt)} : last_ff;
	assign nxt_last_code = win_evt ? win_code : last_code_ff;

	// Read value, taken from next state so a write just before is seen
	always_comb begin
		nxt_hrdata = 32'h0000_0000;
		if (ahb_rd) begin
			case (ahb_ofs)
				`LVF_OFS_MCTRL:     nxt_hrdata = nxt_mctrl;
				`LVF_OFS_FCTRL:     nxt_hrdata = nxt_fctrl;
				`LVF_OFS_STATUS:    nxt_hrdata = {24'h00_0000, nxt_status};
				`LVF_OFS_IRQ_EN:    nxt_hrdata = {24'h00_0000, nxt_irq_en};
				`LVF_OFS_LAST:      nxt_hrdata = nxt_last;
				`LVF_OFS_LAST_CODE: nxt_hrdata = nxt_last_code;
				default:            nxt_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ***************************************************************
	// Flip-flops
	// ***************************************************************

	// Software-visible registers
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mctrl_ff     <= `LVF_MCTRL_RST;
			fctrl_ff     <= `LVF_FCTRL_RST;
			status_ff    <= 8'h00;
			irq_en_ff    <= `LVF_IRQ_EN_RST;
			last_ff      <= 32'h0000_0000;
			last_code_ff <= 32'h0000_0000;
		end else begin
			mctrl_ff     <= nxt_mctrl;
			fctrl_ff     <= nxt_fctrl;
			status_ff    <= nxt_status;
			irq_en_ff    <= nxt_irq_en;
			last_ff      <= nxt_last;
			last_code_ff <= nxt_last_code;
		end
	end

	// Bus data-phase tracking
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff  <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= ahb_wr;
			wr_addr_ff <= ahb_wr ? ahb_ofs : wr_addr_ff;
			hrdata_ff  <= nxt_hrdata;
		end
	end

	// Registered answer to the pipeline
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign rsp_o       = rsp_ff;
	assign hreadyout_o = 1'b1;      // No wait states
	assign hresp_o     = 1'b0;      // Always OKAY
	assign hrdata_o    = hrdata_ff;
	assign irq_o       = |(status_ff & irq_en_ff);

	// hsize is accepted as word; narrower sizes act as a word access
	wire logic unused_ok = &{1'b0, hsize_i, haddr_i[31:8]};

endmodule : lvf_top

/* File: bench/lvf_top_props.sv */
// Purpose: port checks for the legacy vector fault check block.
// Assumes: one answer one cycle after each request.
// Notes:   control bits are internal, so only bit-free relations here.
`timescale 1ns/1ps
module lvf_top_props
	import lvf_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          sys_rst_i,
	input  lvf_pkg::lvf_req_t  req_i,
	input  lvf_pkg::lvf_rsp_t  rsp_o
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// No request of a higher category
	wire no_upper = !req_i.prev_trap && !req_i.ext_intr && !req_i.fetch_flt && !req_i.decode_flt;
	rsp_timing_a: assert property (rsp_o.valid == $past(req_i.valid))
		else $error("answer strobe not one cycle after request");
	trap_first_a: assert property (
		req_i.valid && req_i.prev_trap |=> rsp_o.cat == CAT_TRAP && rsp_o.fault == FLT_NONE)
		else $error("trap not ranked first");
	intr_next_a: assert property (
		req_i.valid && !req_i.prev_trap && req_i.ext_intr |=> rsp_o.cat == CAT_INTR)
		else $error("interrupt not ranked second");
	lock_ud_a: assert property (
		req_i.valid && no_upper && req_i.lock_pfx |=> rsp_o.fault == FLT_UD
		&& rsp_o.vector == 8'h06) else $error("lock prefix not invalid opcode");
	feat_ud_a: assert property (
		req_i.valid && no_upper && !req_i.feat_ok |=> rsp_o.fault == FLT_UD)
		else $error("missing feature not invalid opcode");
	dbl_align_a: assert property (
		req_i.valid && no_upper && req_i.mem_op && req_i.grp == GRP_DBL
		&& req_i.addr[3:0] != 4'h0 |=> rsp_o.fault inside {FLT_UD, FLT_NM, FLT_MF, FLT_SS, FLT_GP})
		else $error("misaligned double group passed");
	real_no_pf_a: assert property (rsp_o.fault == FLT_PF |-> $past(req_i.mode) != MODE_REAL)
		else $error("translation fault in real mode");
	pf_code_a: assert property (rsp_o.fault == FLT_PF |-> rsp_o.code_valid
		&& rsp_o.code == $past(req_i.pf_code)) else $error("translation code lost");
	zero_code_a: assert property (
		rsp_o.fault inside {FLT_SS, FLT_GP, FLT_AC} |-> rsp_o.code_valid && rsp_o.code == 32'h0)
		else $error("error code not zero");
	ac_scope_a: assert property (rsp_o.fault == FLT_AC |-> $past(req_i.grp) == GRP_SGL
		&& $past(req_i.cpl) == 2'h3 && $past(req_i.mode) != MODE_REAL)
		else $error("alignment fault out of scope");
	cover property (rsp_o.cat == CAT_TRAP);
	cover property (rsp_o.fault == FLT_AC);
	cover property (rsp_o.fault == FLT_XM);
endmodule : lvf_top_props

bind lvf_top lvf_top_props lvf_top_props_inst (
	.clk_sys_i (clk_sys_i),
	.sys_rst_i (sys_rst_i),
	.req_i     (req_i),
	.rsp_o     (rsp_o)
);

/* File: bench/lvf_pipe_model.sv */
// Purpose: decode and execute pipeline issuing fault check requests.
// Assumes: one strobe per instruction, no ready from the block.
// Notes:   released fields carry the inverse of the last value.
`timescale 1ns/1ps
module lvf_pipe_model
	import lvf_pkg::*;
(
	input  wire logic          clk_sys_i,
	output lvf_pkg::lvf_req_t  req_o
);
	initial req_o = '0;
	// Idle for a while, strobe one request, then drop the strobe
	task automatic send(input lvf_req_t r, input int idle);
		lvf_req_t q;
		repeat (idle) @(posedge clk_sys_i);
		@(posedge clk_sys_i);
		req_o <= r;
		@(posedge clk_sys_i);
		q = ~r;
		q.valid = 1'b0;
		req_o <= q;
	endtask : send
endmodule : lvf_pipe_model

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the legacy vector fault check block.
// Assumes: registers at zero after reset, answer one cycle after request.
// Notes:   scenarios are tasks run in order; state carries over.
`timescale 1ns/1ps
`include "lvf_defines.svh"
module testbench;
	import lvf_pkg::*;
	logic        clk_sys_i;
	logic        sys_rst_i;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hresp;
	logic        irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	lvf_req_t    req;
	lvf_rsp_t    rsp;
	lvf_req_t    r;
	int          miscompares;
	int          n_compared;

	lvf_top lvf_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req),
		.rsp_o(rsp), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .irq_o(irq));
	lvf_pipe_model lvf_pipe_model_inst (.clk_sys_i(clk_sys_i), .req_o(req));

	// ****
	// Shared tasks
	// ****
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// Wait, bounded, for hready high at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			miscompares++;
			conclude();
		end
	endtask : wait_rdy

	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		cmp(hresp, 1'b0);
	endtask : bus

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rdchk

	function automatic lvf_req_t mk(input lvf_mode_t m, input lvf_grp_t g,
		input logic [63:0] a);
		lvf_req_t q;
		q = '0;
		q.valid = 1'b1;
		q.feat_ok = 1'b1;
		q.mem_op = 1'b1;
		q.mode = m;
		q.grp = g;
		q.addr = a;
		return q;
	endfunction : mk

	// Issue one request and judge the whole answer one cycle later
	task automatic chk(input lvf_req_t q, input lvf_cat_t c, input lvf_fault_t f,
		input logic [7:0] v);
		logic cv;
		cv = f inside {FLT_SS, FLT_GP, FLT_AC, FLT_PF};
		lvf_pipe_model_inst.send(q, 0);
		#1;
		cmp({rsp.valid, rsp.cat, rsp.fault, rsp.vector, rsp.code_valid, rsp.code},
			{1'b1, c, f, v, cv, (f == FLT_PF) ? q.pf_code : 32'h0});
	endtask : chk

	// ****
	// Scenarios
	// ****
	task automatic t_regs();
		rdchk(`LVF_OFS_MCTRL, 32'h0);
		rdchk(`LVF_OFS_FCTRL, 32'h0);
		rdchk(`LVF_OFS_STATUS, 32'h0);
		rdchk(`LVF_OFS_IRQ_EN, 32'h0);
		rdchk(32'h40, 32'h0);
		cmp(irq, 1'b0);
		chk(mk(MODE_PROT, GRP_SGL, 64'h0), CAT_EXEC, FLT_UD, 8'h06);
		bus(1'b1, `LVF_OFS_FCTRL, 32'h0000_0200);
		rdchk(`LVF_OFS_FCTRL, 32'h0000_0200);
		$display("test regs done");
	endtask : t_regs

	task automatic t_category();
		r = mk(MODE_PROT, GRP_SGL, 64'h0);
		r.lock_pfx = 1'b1;
		r.decode_flt = 1'b1;
		chk(r, CAT_DECODE, FLT_NONE, 8'h00);
		r.fetch_flt = 1'b1;
		chk(r, CAT_FETCH, FLT_NONE, 8'h00);
		r.ext_intr = 1'b1;
		chk(r, CAT_INTR, FLT_NONE, 8'h00);
		r.prev_trap = 1'b1;
		chk(r, CAT_TRAP, FLT_NONE, 8'h00);
		$display("test category done");
	endtask : t_category

	task automatic t_invalid();
		r = mk(MODE_REAL, GRP_DBL, 64'h0);
		r.lock_pfx = 1'b1;
		chk(r, CAT_EXEC, FLT_UD, 8'h06);
		r = mk(MODE_V86, GRP_SGL, 64'h0);
		r.feat_ok = 1'b0;
		chk(r, CAT_EXEC, FLT_UD, 8'h06);
		r = mk(MODE_LONG, GRP_SGL, 64'h0);
		r.simd_unm = 1'b1;
		chk(r, CAT_EXEC, FLT_UD, 8'h06);
		bus(1'b1, `LVF_OFS_MCTRL, 32'h0000_0004);
		chk(mk(MODE_PROT, GRP_DBL, 64'h0), CAT_EXEC, FLT_UD, 8'h06);
		bus(1'b1, `LVF_OFS_MCTRL, 32'h0000_0008);
		chk(mk(MODE_REAL, GRP_SGL, 64'h0), CAT_EXEC, FLT_NM, 8'h07);
		bus(1'b1, `LVF_OFS_MCTRL, 32'h0);
		$display("test invalid done");
	endtask : t_invalid

	task automatic t_exec();
		r = mk(MODE_PROT, GRP_SGL, 64'h0);
		r.x87_pend = 1'b1;
		chk(r, CAT_EXEC, FLT_MF, 8'h10);
		bus(1'b1, `LVF_OFS_FCTRL, 32'h0000_0600);
		r = mk(MODE_REAL, GRP_DBL, 64'h0);
		r.simd_unm = 1'b1;
		chk(r, CAT_EXEC, FLT_XM, 8'h13);
		r = mk(MODE_PROT, GRP_SGL, 64'h0);
		r.seg_bad = 1'b1;
		chk(r, CAT_EXEC, FLT_GP, 8'h0D);
		r.ss_seg = 1'b1;
		chk(r, CAT_EXEC, FLT_SS, 8'h0C);
		r = mk(MODE_LONG, GRP_SGL, 64'h0000_8000_0000_0000);
		chk(r, CAT_EXEC, FLT_GP, 8'h0D);
		r.ss_seg = 1'b1;
		chk(r, CAT_EXEC, FLT_SS, 8'h0C);
		chk(mk(MODE_LONG, GRP_SGL, 64'hFFFF_8000_0000_0000), CAT_NONE, FLT_NONE, 8'h00);
		chk(mk(MODE_REAL, GRP_DBL, 64'h8), CAT_EXEC, FLT_GP, 8'h0D);
		chk(mk(MODE_REAL, GRP_SGL, 64'hFFF9), CAT_EXEC, FLT_GP, 8'h0D);
		chk(mk(MODE_V86, GRP_SGL, 64'hFFF8), CAT_NONE, FLT_NONE, 8'h00);
		r = mk(MODE_V86, GRP_SGL, 64'h0);
		r.page_flt = 1'b1;
		r.pf_code = 32'h0000_0005;
		chk(r, CAT_EXEC, FLT_PF, 8'h0E);
		r.mode = MODE_REAL;
		chk(r, CAT_NONE, FLT_NONE, 8'h00);
		rdchk(`LVF_OFS_LAST, 32'h0005_060E);
		rdchk(`LVF_OFS_LAST_CODE, 32'h0000_0005);
		r = mk(MODE_PROT, GRP_SGL, 64'h1);
		r.cpl = 2'h3;
		r.ac_en = 1'b1;
		chk(r, CAT_EXEC, FLT_AC, 8'h11);
		r.mode = MODE_REAL;
		chk(r, CAT_NONE, FLT_NONE, 8'h00);
		r.grp = GRP_DBL;
		r.mode = MODE_V86;
		r.addr = 64'h10;
		chk(r, CAT_NONE, FLT_NONE, 8'h00);
		$display("test exec done");
	endtask : t_exec

	task automatic t_irq();
		rdchk(`LVF_OFS_STATUS, 32'h0000_00FF);
		cmp(irq, 1'b0);
		bus(1'b1, `LVF_OFS_IRQ_EN, 32'h0000_0010);
		#1;
		cmp(irq, 1'b1);
		bus(1'b1, `LVF_OFS_IRQ_CLR, 32'h0000_00FF);
		#1;
		cmp(irq, 1'b0);
		rdchk(`LVF_OFS_STATUS, 32'h0);
		rdchk(`LVF_OFS_IRQ_CLR, 32'h0);
		$display("test irq done");
	endtask : t_irq

	// Reset in mid-run returns control, enable and status registers, the answer and the interrupt to zero
	task automatic t_reset();
		bus(1'b1, `LVF_OFS_MCTRL, 32'h0000_0008);
		chk(mk(MODE_REAL, GRP_SGL, 64'h0), CAT_EXEC, FLT_NM, 8'h07);
		bus(1'b1, `LVF_OFS_IRQ_EN, 32'h0000_0002);
		#1;
		cmp(irq, 1'b1);
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		#1;
		cmp(irq, 1'b0);
		cmp(rsp, 64'h0);
		rdchk(`LVF_OFS_MCTRL, 32'h0);
		rdchk(`LVF_OFS_IRQ_EN, 32'h0);
		rdchk(`LVF_OFS_STATUS, 32'h0);
		chk(mk(MODE_PROT, GRP_SGL, 64'h0), CAT_EXEC, FLT_UD, 8'h06);
		$display("test reset done");
	endtask : t_reset

	// ****
	// Clock and main sequence
	// ****
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		sys_rst_i = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hsize = 3'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		miscompares = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_category();
		t_invalid();
		t_exec();
		t_irq();
		t_reset();
		conclude();
	end
endmodule : testbench
